/* src/acs_consts.svh */
// constants for the converter command decoder and scan sequencer
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
// register indices carried in a register access command
`define ACS_IDX_FIRST_CONTROL_REGISTER 5'h00
`define ACS_IDX_SEQ 5'h01
`define ACS_IDX_DLY_MUX 5'h02
`define ACS_IDX_DLY_GPO 5'h03
`define ACS_IDX_CHMAP_LO 5'h04
`define ACS_IDX_CHMAP_HI 5'h05
`define ACS_IDX_OUTPUT_DIRECTION_REGISTER 5'h06
`define ACS_IDX_PIN_CTRL 5'h07
`define ACS_IDX_STAT 5'h08
`define ACS_IDX_DATA 5'h09
// command byte layout
`define ACS_CMD_FLAG_BIT 7
`define ACS_CMD_KIND_BIT 6
`define ACS_CMD_OP_LSB 4
`define ACS_CMD_RATE_LSB 0
`define ACS_CMD_IDX_LSB 1
`define ACS_CMD_DIR_BIT 0
// conversion command operations
`define ACS_OP_NOP 2'h0
`define ACS_OP_PDN 2'h1
`define ACS_OP_CAL 2'h2
`define ACS_OP_SEQ 2'h3
// power state field codes
`define ACS_PS_CONV 2'h0
`define ACS_PS_SLEEP 2'h1
`define ACS_PS_STBY 2'h2
// first control register fields
`define ACS_FIRST_CONTROL_REGISTER_PD_LSB 0
`define ACS_FIRST_CONTROL_REGISTER_SINGLE_SHOT_SELECT_BIT 2
`define ACS_FIRST_CONTROL_REGISTER_REPEAT_SINGLE_SHOT_BIT 3
`define ACS_FIRST_CONTROL_REGISTER_CAL_LSB 4
`define ACS_FIRST_CONTROL_REGISTER_RST 8'h05
// scan config register fields
`define ACS_SEQ_MODE_LSB 0
`define ACS_SEQ_SETTLE_DELAY_ENABLE_BIT 2
`define ACS_SEQ_MUX_LSB 3
`define ACS_SEQ_RST 8'h00
`define ACS_MODE_SINGLE 2'h0
`define ACS_MODE_SCAN 2'h1
// one byte per channel inside the channel map words, then the status busy bit
`define ACS_CH_EN_BIT 0
`define ACS_CH_ORD_LSB 1
`define ACS_STAT_BUSY_BIT 2
// address strap encoding and fixed address prefix
`define ACS_STRAP_GND 2'h0
`define ACS_STRAP_SDA 2'h2
`define ACS_ADDR_PREFIX 3'h3
// timing counts in core clock cycles
`define ACS_CONV_CYC 64
`define ACS_CAL_CYC 128
`define ACS_DLY_UNIT_CYC 4
`endif

/* src/acs_pkg.sv */
// types shared by the scan sequencer files
package acs_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_settle = 2'b01,
    st_conv = 2'b10,
    st_cal = 2'b11
  } acs_state_t;
endpackage

/* src/acs_link_if.sv */
// byte and read-word carrier between link side and core side
`timescale 1ns/100ps
interface acs_link_if;
  logic wr_tgl;
  logic [7:0] wr_byte;
  logic wr_first;
  logic rd_tgl;
  logic [23:0] rd_word;
  modport link (output wr_tgl, output wr_byte, output wr_first, input rd_tgl, input rd_word);
  modport core (input wr_tgl, input wr_byte, input wr_first, output rd_tgl, output rd_word);
endinterface

/* src/acs_link_side.sv */
// link clock domain: byte capture toward the core, read word back from it
`timescale 1ns/100ps
module acs_link_side (
  input wire logic i_link_clk, // link byte clock
  input wire logic i_rst_b, // core reset, resynchronised here
  input wire logic i_lk_byte_vld, // byte strobe from bit engine
  input wire logic [7:0] i_lk_byte, // received byte
  input wire logic i_lk_first, // byte is first after address
  output logic [23:0] o_lk_rd_word, // register read word
  output logic o_lk_rd_vld, // read word refreshed
  acs_link_if.link lnk // toward the core
);
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic tgl_ff;
  logic [7:0] byte_ff;
  logic first_ff;
  logic rd_meta_ff;
  logic rd_sync_ff;
  logic rd_seen_ff;
  wire rd_new = rd_sync_ff ^ rd_seen_ff;

  always_ff @(posedge i_link_clk) begin
    rst_meta_ff <= i_rst_b;
    rst_sync_ff <= rst_meta_ff;
    rd_meta_ff <= lnk.rd_tgl;
    rd_sync_ff <= rd_meta_ff;
  end

  // held byte stays put until the next strobe, so the core may read it late
  always_ff @(posedge i_link_clk) begin
    if (!rst_sync_ff) begin
      tgl_ff <= 1'b0;
      byte_ff <= 8'h00;
      first_ff <= 1'b0;
    end else if (i_lk_byte_vld) begin
      tgl_ff <= ~tgl_ff;
      byte_ff <= i_lk_byte;
      first_ff <= i_lk_first;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!rst_sync_ff) begin
      rd_seen_ff <= 1'b0;
      o_lk_rd_word <= 24'h000000;
      o_lk_rd_vld <= 1'b0;
    end else begin
      rd_seen_ff <= rd_sync_ff;
      o_lk_rd_vld <= rd_new;
      if (rd_new) begin
        o_lk_rd_word <= lnk.rd_word;
      end
    end
  end

  assign lnk.wr_tgl = tgl_ff;
  assign lnk.wr_byte = byte_ff;
  assign lnk.wr_first = first_ff;
endmodule

/* src/acs_scan_seq.sv */
// command decoder, configuration registers and conversion sequencer
// Overview of operation
// - top two bits set: register access, bits 5..1 index, bit 0 direction
// - direction 0 writes following bytes to the register, 1 returns its contents
// - operation 01 power-down, 10 calibration, 11 run sequencer, 00 unused
// - low four command bits set the rate for later conversions; operation 00 leaves it unchanged
// - power state reads 00 converting, 01 sleep, 10 standby
// - power-down during conversion goes to standby or sleep per choice
// - mode field 00: single channel picked by the input selector
// - settle enable delays every conversion start by the eight-bit delay
// - single mode ignores channel maps and output bias delay
// - output pins follow direction and pin registers, writable any time
// - single-shot select picks one-shot or continuous; repeat makes shots continuous
// - single mode one-shot without repeat sleeps after the conversion
// - continuous or repeating shots run until a power-down or calibration command
// - active-low data ready marks each new result
// - scan mode converts enabled channels in ascending order field value, one channel per nonzero value
// - scan mode ignores bias delay and per-channel output mapping
// - scan mode ignores repeat; host never selects continuous there
// - two three-level straps set four address bits, both on data gives ones
// - top three slave address bits are always 011
// - mode field 01 selects the multichannel scan
`timescale 1ns/100ps
`include "acs_consts.svh"
module acs_scan_seq #(
  parameter int P_CONV_CYC = `ACS_CONV_CYC, // core cycles per conversion
  parameter int P_CAL_CYC = `ACS_CAL_CYC, // core cycles per calibration
  parameter int P_DLY_UNIT = `ACS_DLY_UNIT_CYC // core cycles per settle step
) (
  input wire logic i_clk, // core clock
  input wire logic i_rst_b, // synchronous reset, active low
  input wire logic i_link_clk, // link byte clock
  input wire logic i_lk_byte_vld, // byte strobe, link domain
  input wire logic [7:0] i_lk_byte, // received byte, link domain
  input wire logic i_lk_first, // first byte after address, link domain
  input wire logic [1:0] i_addr_strap_low, // low strap level code
  input wire logic [1:0] i_addr_strap_high, // high strap level code
  input wire logic [23:0] i_mod_result, // modulator result, core domain
  output logic [23:0] o_lk_rd_word, // read word, link domain
  output logic o_lk_rd_vld, // read word refreshed, link domain
  output logic [6:0] o_slave_addr, // seven-bit slave address
  output logic [1:0] o_power_state, // power state field
  output logic o_data_ready_n, // data ready, active low
  output logic o_conv_active, // modulator converting
  output logic [2:0] o_conv_chan, // channel under conversion
  output logic [3:0] o_conv_rate, // applied data rate code
  output logic o_cal_start, // calibration start pulse
  output logic [1:0] o_cal_kind, // calibration kind
  output logic [23:0] o_result, // result register
  output logic [7:0] o_gpo_out, // output pin levels
  output logic [7:0] o_gpo_oe // output pin enables
);
  localparam logic [15:0] LP_CONV_LAST = 16'(P_CONV_CYC - 1);
  localparam logic [15:0] LP_CAL_LAST = 16'(P_CAL_CYC - 1);
  localparam logic [7:0] LP_DLY_UNIT = 8'(P_DLY_UNIT);

  generate
    if (P_CONV_CYC < 1 || P_CONV_CYC > 65536 || P_CAL_CYC < 1 || P_CAL_CYC > 65536 ||
        P_DLY_UNIT < 1 || P_DLY_UNIT > 255) begin : g_bad_param
      $error("acs_scan_seq: count parameter out of range");
    end
  endgenerate

  acs_link_if lnk ();

  acs_link_side u_link (
    .i_link_clk(i_link_clk),
    .i_rst_b(i_rst_b),
    .i_lk_byte_vld(i_lk_byte_vld),
    .i_lk_byte(i_lk_byte),
    .i_lk_first(i_lk_first),
    .o_lk_rd_word(o_lk_rd_word),
    .o_lk_rd_vld(o_lk_rd_vld),
    .lnk(lnk)
  );

  logic wt_meta_ff;
  logic wt_sync_ff;
  logic wt_seen_ff;
  logic [3:0] strap_meta_ff;
  logic [3:0] strap_sync_ff;
  logic cap_done_ff;
  logic wr_armed_ff;
  logic [4:0] wr_idx_ff;
  logic rd_tgl_ff;
  logic [23:0] rd_word_ff;
  logic [7:0] first_control_register_ff;
  logic [7:0] seq_ff;
  logic [7:0] dly_mux_ff;
  logic [7:0] dly_gpo_ff;
  logic [23:0] chmap_lo_ff;
  logic [23:0] chmap_hi_ff;
  acs_pkg::acs_state_t state_ff;
  acs_pkg::acs_state_t nxt_state;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [2:0] nxt_chan;
  logic [2:0] ord_ff;
  logic [2:0] nxt_ord;
  logic scan2_ff;
  logic nxt_scan2;
  logic [1:0] nxt_ps;
  logic nxt_cal;

  // link bytes cross as a toggle; the held byte is stable long before it lands
  wire byte_evt = wt_sync_ff ^ wt_seen_ff;
  wire [7:0] cb = lnk.wr_byte;
  wire is_cmd = byte_evt & lnk.wr_first & cb[`ACS_CMD_FLAG_BIT];
  wire is_reg_cmd = is_cmd & cb[`ACS_CMD_KIND_BIT];
  wire is_conv = is_cmd & ~cb[`ACS_CMD_KIND_BIT];
  wire [1:0] op = cb[`ACS_CMD_OP_LSB +: 2];
  wire [4:0] cmd_idx = cb[`ACS_CMD_IDX_LSB +: 5];
  wire reg_rd_cmd = is_reg_cmd & cb[`ACS_CMD_DIR_BIT];
  wire reg_wr_cmd = is_reg_cmd & ~cb[`ACS_CMD_DIR_BIT];
  wire is_data = byte_evt & ~lnk.wr_first & wr_armed_ff;

  wire [1:0] pd_choice = first_control_register_ff[`ACS_FIRST_CONTROL_REGISTER_PD_LSB +: 2];
  wire single_shot_select = first_control_register_ff[`ACS_FIRST_CONTROL_REGISTER_SINGLE_SHOT_SELECT_BIT];
  wire repeat_single_shot = first_control_register_ff[`ACS_FIRST_CONTROL_REGISTER_REPEAT_SINGLE_SHOT_BIT];
  wire [1:0] seq_mode = seq_ff[`ACS_SEQ_MODE_LSB +: 2];
  wire settle_delay_enable = seq_ff[`ACS_SEQ_SETTLE_DELAY_ENABLE_BIT];
  wire [2:0] mux_sel = seq_ff[`ACS_SEQ_MUX_LSB +: 3];

  wire pdn_cmd = is_conv & (op == `ACS_OP_PDN);
  wire cal_cmd = is_conv & (op == `ACS_OP_CAL);
  wire seq_cmd = is_conv & (op == `ACS_OP_SEQ);
  wire seq1_cmd = seq_cmd & (seq_mode == `ACS_MODE_SINGLE);
  wire seq2_cmd = seq_cmd & (seq_mode == `ACS_MODE_SCAN);
  wire rate_upd = is_conv & (op != `ACS_OP_NOP);
  wire conv_done = (state_ff == acs_pkg::st_conv) & (cnt_ff == 16'h0000);
  wire run_end = (state_ff != acs_pkg::st_idle) & (cnt_ff == 16'h0000);
  // scan mode always behaves as single shot; repeat and continuous are ignored there
  wire one_shot = single_shot_select & ~repeat_single_shot;

  wire we_first_control_register = is_data & (wr_idx_ff == `ACS_IDX_FIRST_CONTROL_REGISTER);
  wire we_seq = is_data & (wr_idx_ff == `ACS_IDX_SEQ);
  wire we_dmux = is_data & (wr_idx_ff == `ACS_IDX_DLY_MUX);
  wire we_dgpo = is_data & (wr_idx_ff == `ACS_IDX_DLY_GPO);
  wire we_cmlo = is_data & (wr_idx_ff == `ACS_IDX_CHMAP_LO);
  wire we_cmhi = is_data & (wr_idx_ff == `ACS_IDX_CHMAP_HI);
  wire we_gdir = is_data & (wr_idx_ff == `ACS_IDX_OUTPUT_DIRECTION_REGISTER);
  wire we_pin = is_data & (wr_idx_ff == `ACS_IDX_PIN_CTRL);
  wire data_rd = reg_rd_cmd & (cmd_idx == `ACS_IDX_DATA);

  // settle delay; the bias delay register is stored but never steers anything
  wire settle_on = settle_delay_enable & (dly_mux_ff != 8'h00);
  wire [15:0] settle_len = {8'h00, dly_mux_ff} * {8'h00, LP_DLY_UNIT};
  acs_pkg::acs_state_t launch_state;
  wire [15:0] launch_cnt = settle_on ? (settle_len - 16'h0001) : LP_CONV_LAST;
  assign launch_state = settle_on ? acs_pkg::st_settle : acs_pkg::st_conv;

  // scan order search: smallest order value above the last one done
  wire [47:0] chmap_all = {chmap_hi_ff, chmap_lo_ff};
  wire [2:0] base_ord = seq2_cmd ? 3'h0 : ord_ff;
  logic [5:0] cand;
  logic [2:0] ch_ord [6];
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_chan
      assign ch_ord[gi] = chmap_all[8 * gi + `ACS_CH_ORD_LSB +: 3];
      assign cand[gi] = chmap_all[8 * gi + `ACS_CH_EN_BIT] & (ch_ord[gi] > base_ord);
    end
  endgenerate

  logic found;
  logic [2:0] best_ord;
  logic [2:0] best_ch;
  always_comb begin
    found = 1'b0;
    best_ord = 3'h7;
    best_ch = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (cand[i] && (!found || ch_ord[i] < best_ord)) begin
        found = 1'b1;
        best_ord = ch_ord[i];
        best_ch = 3'(i);
      end
    end
  end

  // register read answer: unused indices read as zero
  wire [23:0] rd_val =
    (cmd_idx == `ACS_IDX_FIRST_CONTROL_REGISTER) ? {16'h0000, first_control_register_ff} :
    (cmd_idx == `ACS_IDX_SEQ) ? {16'h0000, seq_ff} :
    (cmd_idx == `ACS_IDX_DLY_MUX) ? {16'h0000, dly_mux_ff} :
    (cmd_idx == `ACS_IDX_DLY_GPO) ? {16'h0000, dly_gpo_ff} :
    (cmd_idx == `ACS_IDX_CHMAP_LO) ? chmap_lo_ff :
    (cmd_idx == `ACS_IDX_CHMAP_HI) ? chmap_hi_ff :
    (cmd_idx == `ACS_IDX_OUTPUT_DIRECTION_REGISTER) ? {16'h0000, o_gpo_oe} :
    (cmd_idx == `ACS_IDX_PIN_CTRL) ? {16'h0000, o_gpo_out} :
    (cmd_idx == `ACS_IDX_STAT) ? {21'h0, o_conv_active, o_power_state} :
    (cmd_idx == `ACS_IDX_DATA) ? o_result : 24'h000000;

  wire [1:0] strap_lo_bits = {strap_sync_ff[1:0] == `ACS_STRAP_SDA,
                              strap_sync_ff[1:0] != `ACS_STRAP_GND};
  wire [1:0] strap_hi_bits = {strap_sync_ff[3:2] == `ACS_STRAP_SDA,
                              strap_sync_ff[3:2] != `ACS_STRAP_GND};

  always_ff @(posedge i_clk) begin
    wt_meta_ff <= lnk.wr_tgl;
    wt_sync_ff <= wt_meta_ff;
    strap_meta_ff <= {i_addr_strap_high, i_addr_strap_low};
    strap_sync_ff <= strap_meta_ff;
  end

  // straps are caught once, at the first edge after reset release
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cap_done_ff <= 1'b0;
      o_slave_addr <= {`ACS_ADDR_PREFIX, 4'h0};
    end else if (!cap_done_ff) begin
      cap_done_ff <= 1'b1;
      o_slave_addr <= {`ACS_ADDR_PREFIX, strap_hi_bits, strap_lo_bits};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wt_seen_ff <= 1'b0;
      wr_armed_ff <= 1'b0;
      wr_idx_ff <= 5'h00;
      rd_tgl_ff <= 1'b0;
      rd_word_ff <= 24'h000000;
    end else begin
      wt_seen_ff <= wt_sync_ff;
      if (is_cmd) begin
        wr_armed_ff <= reg_wr_cmd;
        wr_idx_ff <= cmd_idx;
      end
      if (reg_rd_cmd) begin
        rd_tgl_ff <= ~rd_tgl_ff;
        rd_word_ff <= rd_val;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      first_control_register_ff <= `ACS_FIRST_CONTROL_REGISTER_RST;
      seq_ff <= `ACS_SEQ_RST;
      dly_mux_ff <= 8'h00;
      dly_gpo_ff <= 8'h00;
    end else begin
      if (we_first_control_register) first_control_register_ff <= cb;
      if (we_seq) seq_ff <= cb;
      if (we_dmux) dly_mux_ff <= cb;
      if (we_dgpo) dly_gpo_ff <= cb;
    end
  end

  // wide words fill a byte at a time, first byte ends up most significant
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      chmap_lo_ff <= 24'h000000;
      chmap_hi_ff <= 24'h000000;
      o_gpo_oe <= 8'h00;
      o_gpo_out <= 8'h00;
    end else begin
      if (we_cmlo) chmap_lo_ff <= {chmap_lo_ff[15:0], cb};
      if (we_cmhi) chmap_hi_ff <= {chmap_hi_ff[15:0], cb};
      if (we_gdir) o_gpo_oe <= cb;
      if (we_pin) o_gpo_out <= cb;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_chan = o_conv_chan;
    nxt_ord = ord_ff;
    nxt_scan2 = scan2_ff;
    nxt_ps = o_power_state;
    nxt_cal = 1'b0;
    if (pdn_cmd) begin
      nxt_state = acs_pkg::st_idle;
      nxt_scan2 = 1'b0;
      nxt_ps = (pd_choice == `ACS_PS_STBY) ? `ACS_PS_STBY : `ACS_PS_SLEEP;
    end else if (cal_cmd) begin
      nxt_state = acs_pkg::st_cal;
      nxt_cnt = LP_CAL_LAST;
      nxt_scan2 = 1'b0;
      nxt_ps = `ACS_PS_CONV;
      nxt_cal = 1'b1;
    end else if (seq1_cmd) begin
      nxt_chan = mux_sel;
      nxt_scan2 = 1'b0;
      nxt_state = launch_state;
      nxt_cnt = launch_cnt;
      nxt_ps = `ACS_PS_CONV;
    end else if (seq2_cmd || (conv_done && scan2_ff)) begin
      if (found) begin
        nxt_chan = best_ch;
        nxt_ord = best_ord;
        nxt_scan2 = 1'b1;
        nxt_state = launch_state;
        nxt_cnt = launch_cnt;
        nxt_ps = `ACS_PS_CONV;
      end else begin
        nxt_state = acs_pkg::st_idle;
        nxt_scan2 = 1'b0;
        nxt_ps = `ACS_PS_SLEEP;
      end
    end else begin
      unique case (state_ff)
        acs_pkg::st_idle: begin
        end
        acs_pkg::st_settle: begin
          if (cnt_ff == 16'h0000) begin
            nxt_state = acs_pkg::st_conv;
            nxt_cnt = LP_CONV_LAST;
          end else begin
            nxt_cnt = cnt_ff - 16'h0001;
          end
        end
        acs_pkg::st_conv: begin
          if (cnt_ff != 16'h0000) begin
            nxt_cnt = cnt_ff - 16'h0001;
          end else if (one_shot) begin
            nxt_state = acs_pkg::st_idle;
            nxt_ps = `ACS_PS_SLEEP;
          end else begin
            nxt_state = launch_state;
            nxt_cnt = launch_cnt;
          end
        end
        acs_pkg::st_cal: begin
          if (cnt_ff == 16'h0000) begin
            nxt_state = acs_pkg::st_idle;
            nxt_ps = `ACS_PS_SLEEP;
          end else begin
            nxt_cnt = cnt_ff - 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_ff <= acs_pkg::st_idle;
      cnt_ff <= 16'h0000;
      ord_ff <= 3'h0;
      scan2_ff <= 1'b0;
      o_conv_chan <= 3'h0;
      o_power_state <= `ACS_PS_SLEEP;
      o_conv_active <= 1'b0;
      o_cal_start <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ord_ff <= nxt_ord;
      scan2_ff <= nxt_scan2;
      o_conv_chan <= nxt_chan;
      o_power_state <= nxt_ps;
      o_conv_active <= (nxt_state == acs_pkg::st_conv);
      o_cal_start <= nxt_cal;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_conv_rate <= 4'h0;
      o_cal_kind <= 2'h0;
      o_result <= 24'h000000;
      o_data_ready_n <= 1'b1;
    end else begin
      if (rate_upd) o_conv_rate <= cb[`ACS_CMD_RATE_LSB +: 4];
      if (cal_cmd) o_cal_kind <= first_control_register_ff[`ACS_FIRST_CONTROL_REGISTER_CAL_LSB +: 2];
      if (conv_done) o_result <= i_mod_result;
      // a result landing in the read cycle keeps data ready low
      if (conv_done) o_data_ready_n <= 1'b0;
      else if (data_rd) o_data_ready_n <= 1'b1;
    end
  end

  assign lnk.rd_tgl = rd_tgl_ff;
  assign lnk.rd_word = rd_word_ff;

  default clocking cb_core @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  AST_ADDR_PREFIX: assert property (
    cap_done_ff |-> o_slave_addr[6:4] == 3'h3)
    else $error("slave address prefix wrong");
  AST_PDN_STATE: assert property (
    pdn_cmd |=> state_ff == acs_pkg::st_idle &&
      o_power_state == ($past(pd_choice) == 2'h2 ? 2'h2 : 2'h1))
    else $error("power-down did not reach chosen state");
  AST_RATE: assert property (
    rate_upd |=> o_conv_rate == $past(cb[3:0]))
    else $error("rate not taken from command");
  // a run that ends by itself in the same cycle may still move the power state
  AST_NOP: assert property (
    is_conv && op == 2'h0 |=> $stable(o_conv_rate) &&
      ($stable(o_power_state) || $past(run_end)))
    else $error("no-operation command changed state");
  AST_SHOT_SLEEP: assert property (
    conv_done && !scan2_ff && one_shot && !is_conv |=>
      state_ff == acs_pkg::st_idle && o_power_state == 2'h1)
    else $error("one-shot did not sleep");
  AST_CONT: assert property (
    conv_done && !scan2_ff && !one_shot && !is_conv |=>
      state_ff != acs_pkg::st_idle && o_power_state == 2'h0)
    else $error("continuous conversion stopped");
  AST_READY: assert property (
    conv_done |=> !o_data_ready_n ##0 o_result == $past(i_mod_result))
    else $error("data ready not low after result");
  AST_BUSY_PS: assert property (
    state_ff != acs_pkg::st_idle |-> o_power_state == 2'h0)
    else $error("power state not converting while busy");
  AST_WRITE: assert property (
    we_seq |=> seq_ff == $past(cb))
    else $error("register write lost");
  AST_SCAN_ORDER: assert property (
    conv_done && scan2_ff && found && !is_conv |=> ord_ff > $past(ord_ff))
    else $error("scan order not ascending");
  AST_EMPTY_SCAN: assert property (
    seq2_cmd && !found |=> state_ff == acs_pkg::st_idle && o_power_state == 2'h1)
    else $error("empty scan did not sleep");
  AST_MODE1_CHAN: assert property (
    seq1_cmd |=> o_conv_chan == $past(mux_sel) && o_power_state == 2'h0)
    else $error("single mode channel wrong");
  AST_SETTLE: assert property (
    state_ff == acs_pkg::st_settle && cnt_ff == 16'h0000 && !is_conv |=>
      state_ff == acs_pkg::st_conv)
    else $error("settle did not hand over to conversion");
endmodule

/* sim/acs_host_model.sv */
// link-side host model: sends command and data bytes, collects read answers
`timescale 1ns/100ps
module acs_host_model (
  input wire logic i_link_clk, // link byte clock
  input wire logic i_rd_vld, // read answer strobe
  input wire logic [23:0] i_rd_word, // read answer word
  output logic o_vld, // byte strobe
  output logic [7:0] o_byte, // byte value
  output logic o_first // command byte marker
);
  logic seen = 1'b0;
  logic [23:0] got = 24'h000000;
  initial begin
    o_vld = 1'b0;
    o_byte = 8'h00;
    o_first = 1'b0;
  end
  // answer lands a few link cycles after the command strobe, once send has returned
  always @(posedge i_link_clk) begin
    if (i_rd_vld === 1'b1) begin
      got = i_rd_word;
      seen = 1'b1;
    end
  end
  // two idle cycles after each strobe keep strobes at least three link cycles apart
  task automatic send(input logic first, input logic [7:0] b);
    @(posedge i_link_clk);
    #1;
    o_vld = 1'b1;
    o_byte = b;
    o_first = first;
    @(posedge i_link_clk);
    #1;
    o_vld = 1'b0;
    o_byte = ~b; // released lines do not keep the last byte
    o_first = ~first;
    @(posedge i_link_clk);
  endtask
  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    send(1'b1, {2'b11, idx, 1'b0});
    send(1'b0, d);
  endtask
  task automatic read(input logic [4:0] idx, output logic [23:0] w);
    seen = 1'b0;
    send(1'b1, {2'b11, idx, 1'b1});
    for (int n = 0; n < 8 && !seen; n++) begin
      @(posedge i_link_clk);
    end
    w = seen ? got : 24'hxxxxxx;
  endtask
endmodule

/* sim/test_adc_command_and_scan_sequencer.sv */
// self-checking bench for the command decoder and scan sequencer
`timescale 1ns/100ps
module test_adc_command_and_scan_sequencer;
  localparam logic [23:0] RES = 24'h00a5c3;
  logic i_clk = 1'b0;
  logic i_link_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic vld, first, rd_vld, dr_n, act, calp;
  logic act_q = 1'b0;
  logic [8:0] chlog = 9'h000;
  logic [7:0] byt, goe, gout;
  logic [23:0] rd_word, res, w;
  logic [6:0] addr;
  logic [1:0] pst, ckind;
  logic [2:0] chan;
  logic [3:0] rate;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int busy = 0;
  int actc = 0;
  int ncal = 0;
  always #2 i_clk = ~i_clk;
  always #62.5 i_link_clk = ~i_link_clk;
  acs_scan_seq #(.P_CONV_CYC(4), .P_CAL_CYC(4), .P_DLY_UNIT(1)) acs_scan_seq_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_link_clk(i_link_clk), .i_lk_byte_vld(vld),
    .i_lk_byte(byt), .i_lk_first(first), .i_addr_strap_low(2'h2), .i_addr_strap_high(2'h1),
    .i_mod_result(RES), .o_lk_rd_word(rd_word), .o_lk_rd_vld(rd_vld), .o_slave_addr(addr),
    .o_power_state(pst), .o_data_ready_n(dr_n), .o_conv_active(act), .o_conv_chan(chan),
    .o_conv_rate(rate), .o_cal_start(calp), .o_cal_kind(ckind), .o_result(res),
    .o_gpo_out(gout), .o_gpo_oe(goe));
  acs_host_model acs_host_model_i (.i_link_clk(i_link_clk), .i_rd_vld(rd_vld),
    .i_rd_word(rd_word), .o_vld(vld), .o_byte(byt), .o_first(first));
  // core-rate watch: pulses and cycle counts are too quick for link-paced tasks
  always @(posedge i_clk) begin
    act_q <= act;
    if (act && !act_q) chlog <= {chlog[5:0], chan};
    if (pst == 2'h0) busy++;
    if (act) actc++;
    if (calp) ncal++;
  end
  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wait_rdy();
    for (int n = 0; n < 300 && dr_n !== 1'b0; n++) begin
      @(posedge i_clk);
    end
  endtask
  task automatic t_reset();
    check("addr", 24'h000037, {17'h0, addr});
    check("pstate", 24'h000001, {22'h0, pst});
  endtask
  task automatic t_regs();
    acs_host_model_i.wr(5'h01, 8'h08);
    acs_host_model_i.read(5'h01, w);
    check("seq", 24'h000008, w);
    acs_host_model_i.read(5'h1f, w);
    check("unmapped", 24'h000000, w);
    acs_host_model_i.wr(5'h06, 8'h3c);
    check("gpo_oe", 24'h00003c, {16'h0, goe});
  endtask
  task automatic t_single();
    acs_host_model_i.send(1'b1, 8'hb5);
    wait_rdy();
    check("ready", 24'h000000, {23'h0, dr_n});
    check("result", RES, res);
    check("chan", 24'h000001, {21'h0, chan});
    check("rate", 24'h000005, {20'h0, rate});
    check("sleep", 24'h000001, {22'h0, pst});
  endtask
  task automatic t_cont();
    acs_host_model_i.wr(5'h00, 8'h02);
    acs_host_model_i.send(1'b1, 8'hb3);
    acs_host_model_i.wr(5'h07, 8'h5a);
    check("gpo_out", 24'h00005a, {16'h0, gout});
    acs_host_model_i.read(5'h09, w);
    check("data", RES, w);
    check("running", 24'h000000, {22'h0, pst});
    check("active", 24'h000001, {23'h0, act});
    acs_host_model_i.send(1'b1, 8'h87);
    check("nop_rate", 24'h000003, {20'h0, rate});
    check("nop_state", 24'h000000, {22'h0, pst});
    acs_host_model_i.send(1'b1, 8'h90);
    check("standby", 24'h000002, {22'h0, pst});
  endtask
  // repeating shots, then a channel change done the host's way
  task automatic t_chg();
    acs_host_model_i.wr(5'h00, 8'h0d);
    acs_host_model_i.send(1'b1, 8'hb1);
    check("repeat", 24'h000000, {22'h0, pst});
    acs_host_model_i.send(1'b1, 8'h91);
    check("exit", 24'h000001, {22'h0, pst});
    acs_host_model_i.wr(5'h01, 8'h10);
    acs_host_model_i.send(1'b1, 8'hb1);
    check("new_chan", 24'h000002, {21'h0, chan});
    check("rerun", 24'h000000, {22'h0, pst});
    acs_host_model_i.send(1'b1, 8'h91);
  endtask
  task automatic t_cal();
    acs_host_model_i.wr(5'h00, 8'h25);
    ncal = 0;
    acs_host_model_i.send(1'b1, 8'ha6);
    check("cal_pulse", 24'h000001, 24'(ncal));
    check("cal_kind", 24'h000002, {22'h0, ckind});
    check("cal_done", 24'h000001, {22'h0, pst});
    check("cal_rate", 24'h000006, {20'h0, rate});
  endtask
  task automatic t_scan();
    acs_host_model_i.wr(5'h00, 8'h05);
    acs_host_model_i.wr(5'h01, 8'h01);
    acs_host_model_i.read(5'h09, w);
    check("data_clr", RES, w);
    acs_host_model_i.send(1'b1, 8'hb0);
    check("empty_sleep", 24'h000001, {22'h0, pst});
    check("empty_ready", 24'h000001, {23'h0, dr_n});
    // order: ch2 (1), ch3 (2), ch0 (3); settle 2 steps; bias delay must not count
    acs_host_model_i.wr(5'h02, 8'h02);
    acs_host_model_i.wr(5'h03, 8'h40);
    acs_host_model_i.wr(5'h04, 8'h03);
    acs_host_model_i.send(1'b0, 8'h00);
    acs_host_model_i.send(1'b0, 8'h07);
    acs_host_model_i.wr(5'h05, 8'h05);
    acs_host_model_i.wr(5'h01, 8'h05);
    busy = 0;
    actc = 0;
    acs_host_model_i.send(1'b1, 8'hb0);
    check("scan_order", 24'h000098, {15'h0, chlog});
    check("scan_conv", 24'd12, 24'(actc));
    check("scan_busy", 24'd18, 24'(busy));
    check("scan_sleep", 24'h000001, {22'h0, pst});
    check("scan_ready", 24'h000000, {23'h0, dr_n});
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // whole run needs about 5000 core cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 12000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    // link side needs several link edges in reset, longer than two core cycles
    repeat (4) @(posedge i_link_clk);
    @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    repeat (4) @(posedge i_link_clk);
    t_reset();
    t_regs();
    t_single();
    t_cont();
    t_chg();
    t_cal();
    t_scan();
    end_sim();
  end
endmodule
